// >>> smseq_pkg.sv
// Package: register map, control fields, modes and serial word layout for the step sequencer
package smseq_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [3:0] SMSEQ_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] SMSEQ_ADDR_STATUS = 4'h4;
    localparam int         SMSEQ_ADDR_W      = 4;
    localparam int         SMSEQ_DATA_W      = 32;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int SMSEQ_CTRL_CLEAR_BIT = 0;
    localparam int SMSEQ_CTRL_DIR_BIT   = 1;
    localparam int SMSEQ_CTRL_SELL_BIT  = 2;
    localparam int SMSEQ_CTRL_SELH_BIT  = 3;
    localparam int SMSEQ_CTRL_BOOST_BIT = 4;
    localparam logic [4:0] SMSEQ_CTRL_RESET = 5'h01;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int SMSEQ_STAT_POS_LSB  = 0;
    localparam int SMSEQ_STAT_RDBK_BIT = 8;
    localparam int SMSEQ_STAT_MODE_LSB = 9;

    // ----------------------------------------------------------------
    // Sequence and serial word layout
    // ----------------------------------------------------------------
    localparam int         SMSEQ_POS_W      = 5;
    localparam logic [2:0] SMSEQ_HALF_SUB   = 3'h4;
    localparam logic [2:0] SMSEQ_LVL_EQUAL  = 3'h4;
    localparam logic [2:0] SMSEQ_LVL_MAX    = 3'h7;
    localparam int         SMSEQ_WORD_W     = 4;
    localparam logic [2:0] SMSEQ_BURST_LAST = 3'h7;

    typedef enum logic [1:0] {
        SMSEQ_MODE_FULL,
        SMSEQ_MODE_HALF,
        SMSEQ_MODE_QUARTER,
        SMSEQ_MODE_EIGHTH
    } smseq_mode_e;

    typedef struct packed {
        logic boost;
        logic sel_high;
        logic sel_low;
        logic direction;
        logic clear;
    } smseq_ctrl_s;

    typedef struct packed {
        logic [SMSEQ_ADDR_W-1:0] address;
        logic                    read;
        logic                    write;
        logic [SMSEQ_DATA_W-1:0] writedata;
    } smseq_avm_req_s;

endpackage

// >>> smseq_top.sv
// Step sequencer: register slave, input clock sampling, position counter and serial bursts

// Operation
// RULE1 - Host holds controls static, toggles clock only
// RULE2 - Host changes mode only while readback low
// RULE3 - Full step with boost raised gives maximum torque
// RULE4 - Both selects high gives eighth-step bursts
// RULE5 - Low select dropped gives quarter-step sequencing
// RULE6 - Driver inputs refresh at eight times step rate; code sends one burst per 8, 4, 2 or 1 input clocks by mode
// RULE7 - Mode change takes effect within one clock
// RULE8 - Counter clear costs one extra clock interval
// RULE9 - Host clock high 4.5us, low 0.5us minimum
// RULE10 - Host may latch static controls from bus
// RULE11 - Burst rate scales with mode, step rate fixed
// RULE12 - Host changes boost only in full step, readback low
// RULE13 - Readback low at the four half-step positions
// RULE14 - Select encodings give half and full step
// RULE15 - Direction sets counter advance or retreat
module smseq_top
(
    // Clock and reset
    input  wire logic                              mclk,
    input  wire logic                              rst,
    // Avalon-MM slave
    input  wire logic [smseq_pkg::SMSEQ_ADDR_W-1:0] avs_address,
    input  wire logic                              avs_read,
    input  wire logic                              avs_write,
    input  wire logic [smseq_pkg::SMSEQ_DATA_W-1:0] avs_writedata,
    output logic      [smseq_pkg::SMSEQ_DATA_W-1:0] avs_readdata,
    output logic                                   avs_waitrequest,
    // Link from host
    input  wire logic                              step_clock_in,
    // Power driver serial side
    output logic                                   serial_clock,
    output logic                                   phase_a_data,
    output logic                                   phase_b_data,
    output logic                                   load_strobe,
    output logic                                   half_step_readback
);
    import smseq_pkg::*;

    // ----------------------------------------------------------------
    // Register slave
    // ----------------------------------------------------------------
    smseq_avm_req_s              req;
    smseq_ctrl_s                 ctrl_q;
    logic                        wait_q;
    logic [SMSEQ_DATA_W-1:0]     rdata_q;
    logic [SMSEQ_DATA_W-1:0]     rdata_d;
    logic [SMSEQ_POS_W-1:0]      pos_q;
    smseq_mode_e                 mode_q;
    logic                        rdbk_q;

    assign req = '{address: avs_address, read: avs_read, write: avs_write,
                   writedata: avs_writedata};

    wire hit_ctrl   = (req.address == SMSEQ_ADDR_CTRL);
    wire hit_status = (req.address == SMSEQ_ADDR_STATUS);
    wire wr_commit  = req.write && !wait_q && hit_ctrl;

    always_comb
    begin
        rdata_d = '0;
        if (hit_ctrl)
        begin
            rdata_d[4:0] = ctrl_q;
        end
        else if (hit_status)
        begin
            rdata_d[SMSEQ_STAT_POS_LSB +: SMSEQ_POS_W] = pos_q;
            rdata_d[SMSEQ_STAT_RDBK_BIT]             = rdbk_q;
            rdata_d[SMSEQ_STAT_MODE_LSB +: 2]        = mode_q;
        end
    end

    // One wait cycle per access; read data is captured on the first cycle, control writes commit on the second
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wait_q  <= 1'b1;
            rdata_q <= '0;
            ctrl_q  <= smseq_ctrl_s'(SMSEQ_CTRL_RESET);
        end
        else
        begin
            wait_q <= !((req.read || req.write) && wait_q);
            if ((req.read || req.write) && wait_q)
            begin
                rdata_q <= rdata_d;
            end
            if (wr_commit)
            begin
                ctrl_q <= smseq_ctrl_s'(req.writedata[4:0]);
            end
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdata_q;

    // ----------------------------------------------------------------
    // Input clock sampling
    // ----------------------------------------------------------------
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end
        else
        begin
            sync1_q <= step_clock_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    wire link_edge = sync2_q && !sync3_q;

    // ----------------------------------------------------------------
    // Mode decode and position counter
    // ----------------------------------------------------------------
    smseq_mode_e mode_d;
    assign mode_d = ctrl_q.sel_high ?
                    (ctrl_q.sel_low ? SMSEQ_MODE_EIGHTH : SMSEQ_MODE_QUARTER) : // RULE4 RULE5
                    (ctrl_q.sel_low ? SMSEQ_MODE_HALF   : SMSEQ_MODE_FULL);     // RULE14

    logic                   clr_pend_q;
    logic [SMSEQ_POS_W-1:0] pos_d;

    // Direction picks the walk through the current table
    assign pos_d = ctrl_q.direction ? pos_q - 5'h01 : pos_q + 5'h01; // RULE15

    wire [2:0] sub_d = pos_d[2:0];
    wire [1:0] quad_d = pos_d[4:3];

    // Burst spacing in input clocks: 8, 4, 2 or 1 depending on mode
    logic emit_d;
    always_comb
    begin
        unique case (mode_d) // RULE11 RULE6
            SMSEQ_MODE_FULL:    emit_d = (sub_d == SMSEQ_HALF_SUB);
            SMSEQ_MODE_HALF:    emit_d = (sub_d[1:0] == 2'h0);
            SMSEQ_MODE_QUARTER: emit_d = !sub_d[0];
            SMSEQ_MODE_EIGHTH:  emit_d = 1'b1;
        endcase
    end

    function automatic logic [2:0] cos_level(input logic [3:0] k);
        logic [2:0] lvl;
        lvl = 3'h0;
        case (k)
            4'h0: lvl = 3'h7;
            4'h1: lvl = 3'h7;
            4'h2: lvl = 3'h6;
            4'h3: lvl = 3'h5;
            4'h4: lvl = 3'h4;
            4'h5: lvl = 3'h3;
            4'h6: lvl = 3'h2;
            4'h7: lvl = 3'h1;
            default: lvl = 3'h0;
        endcase
        return lvl;
    endfunction

    wire [3:0] k_near = {1'b0, sub_d};
    wire [3:0] k_far  = 4'h8 - {1'b0, sub_d};
    wire       odd_q  = quad_d[0];
    wire [2:0] lvl_a  = odd_q ? cos_level(k_far) : cos_level(k_near);
    wire [2:0] lvl_b  = odd_q ? cos_level(k_near) : cos_level(k_far);
    wire       neg_a  = (quad_d == 2'h1) || (quad_d == 2'h2);
    wire       neg_b  = quad_d[1];

    // Boosted full step drives both phases at full current
    wire boost_on = (mode_d == SMSEQ_MODE_FULL) && ctrl_q.boost; // RULE3
    wire [SMSEQ_WORD_W-1:0] word_a = {neg_a, boost_on ? SMSEQ_LVL_MAX : lvl_a};
    wire [SMSEQ_WORD_W-1:0] word_b = {neg_b, boost_on ? SMSEQ_LVL_MAX : lvl_b};

    logic                    emit_q;
    logic [SMSEQ_WORD_W-1:0] word_a_q;
    logic [SMSEQ_WORD_W-1:0] word_b_q;

    // Mode, direction and boost are taken at every input clock edge, so a change lands within one period; clear acts at once
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pos_q      <= '0;
            clr_pend_q <= 1'b1;
            mode_q     <= SMSEQ_MODE_FULL;
            emit_q     <= 1'b0;
            word_a_q   <= '0;
            word_b_q   <= '0;
        end
        else if (ctrl_q.clear)
        begin
            pos_q      <= '0;
            clr_pend_q <= 1'b1;
            emit_q     <= 1'b0;
        end
        else
        begin
            emit_q <= 1'b0;
            if (link_edge)
            begin
                mode_q  <= mode_d; // RULE7
                if (clr_pend_q)
                begin
                    clr_pend_q <= 1'b0; // RULE8
                end
                else
                begin
                    pos_q    <= pos_d;
                    emit_q   <= emit_d;
                    word_a_q <= word_a;
                    word_b_q <= word_b;
                end
            end
        end
    end

    // Readback low at the equal-current positions
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rdbk_q <= 1'b1;
        end
        else
        begin
            rdbk_q <= (pos_q[2:0] != SMSEQ_HALF_SUB); // RULE13
        end
    end

    assign half_step_readback = rdbk_q;

    // ----------------------------------------------------------------
    // Serial burst: two mclk per bit, strobe on the last high phase
    // ----------------------------------------------------------------
    logic       busy_q;
    logic [2:0] bcnt_q;
    logic [SMSEQ_WORD_W-1:0] sh_a_q;
    logic [SMSEQ_WORD_W-1:0] sh_b_q;
    logic       sclk_q;
    logic       da_q;
    logic       db_q;
    logic       stb_q;

    // A word arriving mid-burst restarts the shift; the newest position wins
    wire [1:0] bit_idx   = 2'h2 - bcnt_q[2:1];
    wire       shift_now = busy_q && bcnt_q[0] && (bcnt_q != SMSEQ_BURST_LAST);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            busy_q <= 1'b0;
            bcnt_q <= '0;
            sh_a_q <= '0;
            sh_b_q <= '0;
            sclk_q <= 1'b1;
            da_q   <= 1'b0;
            db_q   <= 1'b0;
            stb_q  <= 1'b0;
        end
        else
        begin
            if (emit_q)
            begin
                busy_q <= 1'b1;
                bcnt_q <= '0;
                sh_a_q <= word_a_q;
                sh_b_q <= word_b_q;
            end
            else if (busy_q)
            begin
                bcnt_q <= bcnt_q + 3'h1;
                busy_q <= (bcnt_q != SMSEQ_BURST_LAST);
            end
            sclk_q <= emit_q ? 1'b0 : !shift_now;
            da_q   <= emit_q ? word_a_q[SMSEQ_WORD_W-1] : shift_now ? sh_a_q[bit_idx] : da_q;
            db_q   <= emit_q ? word_b_q[SMSEQ_WORD_W-1] : shift_now ? sh_b_q[bit_idx] : db_q;
            stb_q  <= busy_q && !emit_q && (bcnt_q == SMSEQ_BURST_LAST - 3'h1);
        end
    end

    assign serial_clock = sclk_q;
    assign phase_a_data = da_q;
    assign phase_b_data = db_q;
    assign load_strobe  = stb_q;
endmodule

// >>> smseq_monitor.sv
// Checker: bus handshake, serial burst shape and readback at the sequencer ports
module smseq_monitor
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Link and serial side
    input wire logic step_clock_in,
    input wire logic serial_clock,
    input wire logic phase_a_data,
    input wire logic phase_b_data,
    input wire logic load_strobe,
    input wire logic half_step_readback
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_WAIT_ONE: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("answer not one cycle after request");
    AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    AST_IDLE_WAIT: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without a request");
    AST_STROBE_ONE: assert property (load_strobe |=> !load_strobe)
        else $error("strobe wider than one cycle");
    AST_STROBE_HIGH: assert property (load_strobe |-> serial_clock)
        else $error("strobe outside a clock high phase");
    // Strobe closes an eight cycle burst of alternating clock phases
    AST_BURST_SHAPE: assert property (
        load_strobe |-> !$past(serial_clock, 1) && $past(serial_clock, 6)
            && !$past(serial_clock, 7))
        else $error("burst shape wrong before strobe");
    AST_CLK_LOW_ONE: assert property ($fell(serial_clock) |=> serial_clock)
        else $error("serial clock low longer than one cycle");
    AST_DATA_HOLD: assert property (
        $rose(serial_clock) |-> $stable(phase_a_data) && $stable(phase_b_data))
        else $error("phase data moved at clock rise");
    AST_READBACK_QUIET: assert property (
        $stable(step_clock_in) [*6] |=> $stable(half_step_readback))
        else $error("readback moved without a step");

    cover property (load_strobe);
    cover property (!half_step_readback);
    cover property (avs_read && !avs_waitrequest);
endmodule

// >>> smseq_drv_model.sv
// Power driver model: shifts in both phase words and latches them on the strobe
module smseq_drv_model
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Serial side
    input  wire logic       serial_clock,
    input  wire logic       phase_a_data,
    input  wire logic       phase_b_data,
    input  wire logic       load_strobe,
    // Observation
    output logic      [7:0] word_count,
    output logic      [7:0] last_word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       sc_q;
    logic [2:0] sha_q;
    logic [2:0] shb_q;
    wire        rise = serial_clock && !sc_q;

    // Strobe shares its cycle with the last rise, so the latch takes the live bit
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sc_q <= 1'b1;
            sha_q <= 3'h0;
            shb_q <= 3'h0;
            word_count <= 8'h00;
            last_word <= 8'h00;
        end
        else
        begin
            sc_q <= serial_clock;
            if (rise)
            begin
                sha_q <= {sha_q[1:0], phase_a_data};
                shb_q <= {shb_q[1:0], phase_b_data};
            end
            if (load_strobe)
            begin
                last_word <= {sha_q, phase_a_data, shb_q, phase_b_data};
                word_count <= word_count + 8'h01;
            end
        end
    end
endmodule

// >>> smseq_tb_top.sv
// Testbench: register tasks, step clock bursts and mode sequence checks
module smseq_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import smseq_pkg::*;

    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic        wreq;
    logic        stp = 1'b0;
    logic        sc, pa, pb, ls, hr;
    logic [7:0]  wcnt, wlast;
    logic [31:0] q;
    logic [7:0]  c0;
    int          bad_count = 0;
    int          check_count = 0;
    // Per test: control word, edges, bursts, final position, applied mode
    logic [4:0]  t_ctl [6] = '{5'h0c, 5'h08, 5'h04, 5'h00, 5'h10, 5'h12};
    int          t_edg [6] = '{5, 8, 8, 8, 8, 1};
    logic [7:0]  t_bur [6] = '{8'h4, 8'h4, 8'h2, 8'h1, 8'h1, 8'h0};
    logic [4:0]  t_pos [6] = '{5'h04, 5'h0c, 5'h14, 5'h1c, 5'h04, 5'h03};
    logic [1:0]  t_mod [6] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0};

    always #50 mclk = ~mclk;

    smseq_top smseq_top_inst (.mclk(mclk), .rst(rst), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .step_clock_in(stp), .serial_clock(sc), .phase_a_data(pa), .phase_b_data(pb),
        .load_strobe(ls), .half_step_readback(hr));
    smseq_drv_model smseq_drv_model_inst (.mclk(mclk), .rst(rst), .serial_clock(sc),
        .phase_a_data(pa), .phase_b_data(pb), .load_strobe(ls), .word_count(wcnt),
        .last_word(wlast));

    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // One Avalon-MM access; request held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        i = 0;
        do
        begin
            @(posedge mclk);
            i++;
        end
        while (wreq !== 1'b0 && i < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i >= 20)
        begin
            $display("BAD %0t bus timeout", $time);
            bad_count++;
            give_verdict();
        end
    endtask

    // Step clock: 800 ns period, held still between calls
    task steps(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge mclk);
            stp <= 1'b1;
            repeat (4) @(posedge mclk);
            stp <= 1'b0;
        end
        repeat (16) @(posedge mclk);
    endtask

    initial
    begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        bus(1'b0, SMSEQ_ADDR_CTRL, 32'h0);
        cmp(q, 32'h01, "ctrl reset");
        bus(1'b0, SMSEQ_ADDR_STATUS, 32'h0);
        cmp(q, 32'h100, "status reset");
        bus(1'b1, SMSEQ_ADDR_STATUS, 32'h1f);
        bus(1'b0, 4'h8, 32'h0);
        cmp(q, 32'h0, "unmapped read");
        steps(2);
        cmp(wcnt, 8'h0, "no bursts while cleared");
        for (int t = 0; t < 6; t++)
        begin
            c0 = wcnt;
            // Mode writes land at half-step positions, except the first, which lands at position 0
            bus(1'b1, SMSEQ_ADDR_CTRL, {27'h0, t_ctl[t]});
            steps(t_edg[t]);
            cmp(wcnt - c0, t_bur[t], "burst count");
            bus(1'b0, SMSEQ_ADDR_STATUS, 32'h0);
            cmp(q, {21'h0, t_mod[t], t_pos[t][2:0] != 3'h4, 3'h0, t_pos[t]},
                "status");
            cmp(hr, t_pos[t][2:0] != 3'h4, "readback pin");
            if (t == 3 || t == 4)
                cmp({wlast[6:4], wlast[2:0]}, t == 4 ? 6'h3f : 6'h24, "levels");
            $display("test %0d done", t);
        end
        give_verdict();
    end
endmodule

bind smseq_top smseq_monitor smseq_monitor_inst (.mclk(mclk), .rst(rst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .step_clock_in(step_clock_in), .serial_clock(serial_clock),
    .phase_a_data(phase_a_data), .phase_b_data(phase_b_data),
    .load_strobe(load_strobe), .half_step_readback(half_step_readback));
